// [rtl/mprc_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef MPRC_REGS_SVH
`define MPRC_REGS_SVH
// ---------------------------------------------------------------
// register offsets (8-bit registers, 4-bit address)
// ---------------------------------------------------------------
`define MPRC_A_REG_CTRL   4'h0
`define MPRC_A_SEQ_DELAY  4'h1
`define MPRC_A_SLV_CTRL   4'h2
`define MPRC_A_SLV_DELAY  4'h3
`define MPRC_A_LOAD_SEL   4'h4
`define MPRC_A_LOAD_LO    4'h5
`define MPRC_A_LOAD_HI    4'h6
`define MPRC_A_CLK_CTRL   4'h7
`define MPRC_A_CONFIG     4'h8
`define MPRC_A_TOP_FLAGS  4'h9
`define MPRC_A_TOP_MASK   4'hA
`define MPRC_A_PH_FLAGS   4'hB
`define MPRC_A_PH_MASK    4'hC
`define MPRC_A_STATUS     4'hD
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define MPRC_F_SPREAD     0
`define MPRC_F_DOUBLE     4
`define MPRC_F_HALF       5
`define MPRC_CONFIG_RST   8'h0E
`define MPRC_CLK_CTRL_RST 8'h00
`define MPRC_MODE_RC      2'h0
`define MPRC_MODE_BOTH    2'h1
`define MPRC_MODE_ACTIVE  2'h2
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MPRC_CLK_NS       10
`define MPRC_MEAS_MAX_NS  50000
`define MPRC_SS_MAX_NS    1000000
`define MPRC_STEP_A_NS    320000
`define MPRC_STEP_B_NS    640000
`define MPRC_STEP_C_NS    1000000
`define MPRC_STEP_D_NS    2000000
`define MPRC_POR_CYCLES   16
`define MPRC_PER_MAX      8'hFF
`endif

// [rtl/mprc_pkg.sv]
// types shared by the regulator control block
package mprc_pkg;
  // power-up progression of the device
  typedef enum logic [1:0] {ST_POR, ST_OTP, ST_STANDBY, ST_ACTIVE} mprc_state_e;
  typedef logic [7:0] mprc_byte_t;   // one register
endpackage : mprc_pkg

// [rtl/mprc_top.sv]
// control logic of a four-phase step-down regulator
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "mprc_regs.svh"
`default_nettype none
module mprc_top
  import mprc_pkg::*;
#(
  parameter int MEAS_CYCLES = `MPRC_MEAS_MAX_NS / `MPRC_CLK_NS,
  parameter int SS_CYCLES   = `MPRC_SS_MAX_NS / `MPRC_CLK_NS,
  parameter int STEP_A      = `MPRC_STEP_A_NS / `MPRC_CLK_NS,
  parameter int STEP_B      = `MPRC_STEP_B_NS / `MPRC_CLK_NS,
  parameter int STEP_C      = `MPRC_STEP_C_NS / `MPRC_CLK_NS,
  parameter int STEP_D      = `MPRC_STEP_D_NS / `MPRC_CLK_NS
) (
  input  wire logic        mclk_i,           // 100 MHz clock
  input  wire logic        sys_rst_i,        // async reset, high
  input  wire logic        ce_i,             // clock enable
  input  wire logic        supply_ok_i,      // analog supply above lockout
  input  wire logic        reset_pin_n_i,    // reset pin, low resets
  input  wire logic [3:0]  addr_i,           // register address
  input  wire logic [7:0]  wr_data_i,        // write data
  input  wire logic        wr_i,             // write strobe
  input  wire logic        rd_i,             // read strobe
  output logic      [7:0]  rd_data_o,        // read data, next cycle
  input  wire logic [2:0]  enable_pin_i,     // enable pins a, b, c
  input  wire logic        sync_clock_in_i,  // external sync clock
  input  wire logic [39:0] phase_current_i,  // four 10-bit phase currents
  input  wire logic        vout_above_i,     // output above 0.35 V
  input  wire logic        power_good_i,     // output at power-good level
  input  wire logic [3:0]  phase_ilim_i,     // per-phase current limit
  output logic             regulator_on_o,   // regulator enable
  output logic             slew_ctrl_o,      // slew-rate controlled ramp
  output logic             spread_o,         // spread spectrum active
  output logic             ext_clk_sel_o,    // external clock in use
  output logic      [2:0]  pulldown_o,       // enable pin pulldowns on
  output logic      [2:0]  discharge_o,      // slave discharge enables
  output logic             host_if_en_o,     // host interface enabled
  output logic             irq_out_n_o       // interrupt, active low
);
  import mprc_pkg::*;

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  mprc_state_e state;              // power-up progression
  logic [4:0]  por_cnt;            // power-on reset timer
  mprc_byte_t  reg_ctrl;           // enable bit, pin control, pin choice
  mprc_byte_t  seq_delay;          // startup [3:0], shutdown [7:4]
  logic [2:0]  slv_dis;            // slave discharge bits
  logic [1:0]  load_sel;           // phase to measure
  logic [9:0]  load_res;           // last measurement result
  mprc_byte_t  clk_ctrl;           // mode [1:0], nominal freq [6:2]
  mprc_byte_t  config_r;           // spread, pulldowns, delay step
  logic [2:0]  top_flags;          // ready, clock change, missing clock
  logic [2:0]  top_mask;           // masks for top flags
  logic [5:0]  ph_flags;           // pg, short, current limits
  logic [5:0]  ph_mask;            // masks for phase flags
  logic        meas_busy;          // measurement running
  logic [15:0] meas_cnt;           // measurement timer
  logic        clk_prev;           // last sync clock sample
  logic [7:0]  per_cnt;            // cycles since last sync edge
  logic        clk_valid;          // sync clock inside limits
  logic        ext_sel;            // external clock chosen
  logic        pin_q;              // last selected pin level
  logic        pin_on;             // delayed pin request
  logic        dly_busy;           // delay running
  logic        dly_dir;            // level to apply after delay
  logic [3:0]  dly_left;           // delay steps remaining
  logic [17:0] step_cnt;           // cycles within one step
  logic        ss_done;            // output passed 0.35 V
  logic [16:0] ss_cnt;             // soft start timer
  logic        sc_fault;           // short circuit latched off
  logic        pg_q;               // last power-good level
  logic [3:0]  ilim_q;             // last current-limit levels
  logic        reg_on;             // regulator running

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire pwr_bad  = !supply_ok_i || !reset_pin_n_i;
  wire bus_ok   = (state == ST_STANDBY) || (state == ST_ACTIVE);
  wire wr_en    = wr_i && bus_ok;   // writes before standby are dropped
  wire wr_ctrl  = wr_en && (addr_i == `MPRC_A_REG_CTRL);
  wire wr_dly   = wr_en && (addr_i == `MPRC_A_SEQ_DELAY);
  wire wr_slv   = wr_en && (addr_i == `MPRC_A_SLV_CTRL);
  wire wr_lsel  = wr_en && (addr_i == `MPRC_A_LOAD_SEL);
  wire wr_clk   = wr_en && (addr_i == `MPRC_A_CLK_CTRL);
  wire wr_cfg   = wr_en && (addr_i == `MPRC_A_CONFIG);
  wire wr_tflg  = wr_en && (addr_i == `MPRC_A_TOP_FLAGS);
  wire wr_tmsk  = wr_en && (addr_i == `MPRC_A_TOP_MASK);
  wire wr_pflg  = wr_en && (addr_i == `MPRC_A_PH_FLAGS);
  wire wr_pmsk  = wr_en && (addr_i == `MPRC_A_PH_MASK);

  // ---------------------------------------------------------------
  // regulator control
  // ---------------------------------------------------------------
  wire       en_bit   = reg_ctrl[0];
  wire       pin_ctl  = reg_ctrl[1];
  wire [1:0] pin_sel  = reg_ctrl[3:2];
  // code 3 selects no pin and reads as low
  wire       sel_pin  = (pin_sel == 2'h3) ? 1'b0 : enable_pin_i[pin_sel];
  wire       pin_rise = sel_pin && !pin_q;
  wire       pin_fall = !sel_pin && pin_q;
  // bit path is immediate, delays belong to the pin path only
  wire       want_on  = en_bit && (!pin_ctl || pin_on);
  wire       next_on  = want_on && !sc_fault && bus_ok;
  wire [3:0] edge_code = sel_pin ? seq_delay[3:0] : seq_delay[7:4];

  // step length from double and half bits
  wire [1:0]  dsel = {config_r[`MPRC_F_DOUBLE], config_r[`MPRC_F_HALF]};
  wire [17:0] step_len =
    (dsel == 2'h1) ? 18'(STEP_A) :
    (dsel == 2'h3) ? 18'(STEP_B) :
    (dsel == 2'h0) ? 18'(STEP_C) : 18'(STEP_D);
  wire step_end = (step_cnt == step_len - 18'h1);

  // ---------------------------------------------------------------
  // soft start supervision
  // ---------------------------------------------------------------
  wire ss_timeout = reg_on && !ss_done && !vout_above_i &&
                    (ss_cnt == 17'(SS_CYCLES - 1));

  // ---------------------------------------------------------------
  // load current measurement
  // ---------------------------------------------------------------
  wire [9:0]  ph0 = phase_current_i[9:0];
  wire [9:0]  ph1 = phase_current_i[19:10];
  wire [9:0]  ph2 = phase_current_i[29:20];
  wire [9:0]  ph3 = phase_current_i[39:30];
  wire [11:0] ph_sum = 12'(ph0) + 12'(ph1) + 12'(ph2) + 12'(ph3);
  // total saturates at full scale rather than wrapping
  wire [9:0]  sum_sat = (ph_sum > 12'h3FF) ? 10'h3FF : ph_sum[9:0];
  wire [9:0]  meas_val =
    (load_sel == 2'h0) ? sum_sat :
    (load_sel == 2'h1) ? ph1 :
    (load_sel == 2'h2) ? ph2 : ph3;
  wire meas_end = meas_busy &&
                  (meas_cnt == 16'(MEAS_CYCLES - 1));

  // ---------------------------------------------------------------
  // sync clock detector
  // ---------------------------------------------------------------
  wire [1:0]  mode     = clk_ctrl[1:0];
  wire [4:0]  nom_f    = clk_ctrl[6:2];
  wire        clk_rise = sync_clock_in_i && !clk_prev;
  wire [8:0]  per_len  = 9'(per_cnt) + 9'h1;
  // frequency check without division: 100/p MHz against F
  wire [17:0] p_times  = 18'(per_len) * 18'(nom_f);
  wire        in_lim   = (p_times * 18'd11 >= 18'd1000) &&
                         (p_times * 18'd7 <= 18'd1000);
  wire        det_en   = (mode == `MPRC_MODE_BOTH) ||
                         ((mode == `MPRC_MODE_ACTIVE) &&
                          (state == ST_ACTIVE));
  wire        next_ext = det_en && clk_valid;
  // held off outside rc mode and until the external clock is really let go
  wire        spread_n = config_r[`MPRC_F_SPREAD] && !ext_sel &&
                         (mode == `MPRC_MODE_RC);
  wire        miss_otp = (state == ST_OTP) && (por_cnt == 5'h0) &&
                         (mode == `MPRC_MODE_BOTH) && !clk_valid;
  wire        miss_act = (state == ST_STANDBY) && next_on &&
                         (mode == `MPRC_MODE_ACTIVE) && !clk_valid;

  // ---------------------------------------------------------------
  // interrupt flags
  // ---------------------------------------------------------------
  wire [2:0] top_set = {miss_otp || miss_act,
                        det_en && (next_ext != ext_sel),
                        meas_end};
  wire [5:0] ph_set  = {phase_ilim_i & ~ilim_q,
                        ss_timeout,
                        power_good_i && !pg_q};
  wire [2:0] top_clr = wr_tflg ? wr_data_i[2:0] : 3'h0;
  wire [5:0] ph_clr  = wr_pflg ? wr_data_i[5:0] : 6'h0;
  // set wins over a clear in the same cycle, mask never blocks a set
  wire [2:0] next_tf = (top_flags & ~top_clr) | top_set;
  wire [5:0] next_pf = (ph_flags & ~ph_clr) | ph_set;
  wire next_irq_n = ~(|(next_tf & ~top_mask) |
                      |(next_pf & ~ph_mask));

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [7:0] status = {3'h0, sc_fault, ext_sel, reg_on, 2'(state)};
  wire [7:0] next_rd =
    (addr_i == `MPRC_A_REG_CTRL)  ? reg_ctrl :
    (addr_i == `MPRC_A_SEQ_DELAY) ? seq_delay :
    (addr_i == `MPRC_A_SLV_CTRL)  ? {5'h0, slv_dis} :
    (addr_i == `MPRC_A_LOAD_SEL)  ? {6'h0, load_sel} :
    (addr_i == `MPRC_A_LOAD_LO)   ? load_res[7:0] :
    (addr_i == `MPRC_A_LOAD_HI)   ? {6'h0, load_res[9:8]} :
    (addr_i == `MPRC_A_CLK_CTRL)  ? clk_ctrl :
    (addr_i == `MPRC_A_CONFIG)    ? config_r :
    (addr_i == `MPRC_A_TOP_FLAGS) ? {5'h0, top_flags} :
    (addr_i == `MPRC_A_TOP_MASK)  ? {5'h0, top_mask} :
    (addr_i == `MPRC_A_PH_FLAGS)  ? {2'h0, ph_flags} :
    (addr_i == `MPRC_A_PH_MASK)   ? {2'h0, ph_mask} :
    (addr_i == `MPRC_A_STATUS)    ? status : 8'h00;

  // ---------------------------------------------------------------
  // power-up progression
  // ---------------------------------------------------------------
  // held in por while supply or reset pin is bad
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state   <= ST_POR;
      por_cnt <= 5'h0;
    end
    else if (ce_i)
    begin
      if (pwr_bad)
      begin
        state   <= ST_POR;
        por_cnt <= 5'h0;
      end
      else
        unique case (state)
          ST_POR:
          begin
            por_cnt <= por_cnt + 5'h1;
            if (por_cnt == 5'(`MPRC_POR_CYCLES - 1))
            begin
              state   <= ST_OTP;
              por_cnt <= 5'h0;
            end
          end
          ST_OTP:     state <= ST_STANDBY;
          ST_STANDBY: if (next_on) state <= ST_ACTIVE;
          ST_ACTIVE:  if (!next_on) state <= ST_STANDBY;
        endcase
    end
  end

  // ---------------------------------------------------------------
  // software registers (defaults act as loaded otp values)
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reg_ctrl  <= 8'h00;
      seq_delay <= 8'h00;
      slv_dis   <= 3'h0;
      load_sel  <= 2'h0;
      clk_ctrl  <= `MPRC_CLK_CTRL_RST;
      config_r  <= `MPRC_CONFIG_RST;
      top_mask  <= 3'h0;
      ph_mask   <= 6'h0;
    end
    else if (ce_i)
    begin
      if (pwr_bad)
      begin
        reg_ctrl  <= 8'h00;
        seq_delay <= 8'h00;
        slv_dis   <= 3'h0;
        load_sel  <= 2'h0;
        clk_ctrl  <= `MPRC_CLK_CTRL_RST;
        config_r  <= `MPRC_CONFIG_RST;
        top_mask  <= 3'h0;
        ph_mask   <= 6'h0;
      end
      else
      begin
        if (wr_ctrl) reg_ctrl  <= {4'h0, wr_data_i[3:0]};
        if (wr_dly)  seq_delay <= wr_data_i;
        // slave control keeps only its discharge bits
        if (wr_slv)  slv_dis   <= wr_data_i[2:0];
        if (wr_lsel) load_sel  <= wr_data_i[1:0];
        if (wr_clk)  clk_ctrl  <= {1'b0, wr_data_i[6:0]};
        if (wr_cfg)  config_r  <= {2'h0, wr_data_i[5:0]};
        if (wr_tmsk) top_mask  <= wr_data_i[2:0];
        if (wr_pmsk) ph_mask   <= wr_data_i[5:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // measurement sequencer
  // ---------------------------------------------------------------
  // a write during a run restarts it with the new selection
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meas_busy <= 1'b0;
      meas_cnt  <= 16'h0;
      load_res  <= 10'h0;
    end
    else if (ce_i)
    begin
      if (pwr_bad)
      begin
        meas_busy <= 1'b0;
        load_res  <= 10'h0;
      end
      else if (wr_lsel)
      begin
        meas_busy <= 1'b1;
        meas_cnt  <= 16'h0;
      end
      else if (meas_end)
      begin
        meas_busy <= 1'b0;
        load_res  <= meas_val;
      end
      else if (meas_busy)
        meas_cnt <= meas_cnt + 16'h1;
    end
  end

  // ---------------------------------------------------------------
  // sync clock period check
  // ---------------------------------------------------------------
  // a stalled clock saturates the counter and drops validity
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      clk_prev  <= 1'b0;
      per_cnt   <= 8'h0;
      clk_valid <= 1'b0;
      ext_sel   <= 1'b0;
    end
    else if (ce_i)
    begin
      clk_prev <= sync_clock_in_i;
      ext_sel  <= next_ext;
      if (clk_rise)
      begin
        per_cnt   <= 8'h0;
        clk_valid <= in_lim;
      end
      else if (per_cnt == `MPRC_PER_MAX)
        clk_valid <= 1'b0;
      else
        per_cnt <= per_cnt + 8'h1;
    end
  end

  // ---------------------------------------------------------------
  // enable pin delays
  // ---------------------------------------------------------------
  // a new edge always restarts the pending delay
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pin_q    <= 1'b0;
      pin_on   <= 1'b0;
      dly_busy <= 1'b0;
      dly_dir  <= 1'b0;
      dly_left <= 4'h0;
      step_cnt <= 18'h0;
    end
    else if (ce_i)
    begin
      pin_q <= sel_pin;
      if (pin_rise || pin_fall)
      begin
        step_cnt <= 18'h0;
        dly_dir  <= sel_pin;
        dly_left <= edge_code;
        if (edge_code == 4'h0)
        begin
          pin_on   <= sel_pin;
          dly_busy <= 1'b0;
        end
        else
          dly_busy <= 1'b1;
      end
      else if (dly_busy)
      begin
        step_cnt <= step_end ? 18'h0 : step_cnt + 18'h1;
        if (step_end)
        begin
          dly_left <= dly_left - 4'h1;
          if (dly_left == 4'h1)
          begin
            pin_on   <= dly_dir;
            dly_busy <= 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // soft start and regulator output
  // ---------------------------------------------------------------
  // a short circuit holds the regulator off until the request drops
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reg_on   <= 1'b0;
      ss_done  <= 1'b0;
      ss_cnt   <= 17'h0;
      sc_fault <= 1'b0;
    end
    else if (ce_i)
    begin
      reg_on <= next_on && !ss_timeout;
      if (!want_on)
        sc_fault <= 1'b0;
      else if (ss_timeout)
        sc_fault <= 1'b1;
      if (!reg_on)
      begin
        ss_done <= 1'b0;
        ss_cnt  <= 17'h0;
      end
      else if (vout_above_i)
        ss_done <= 1'b1;
      else if (!ss_done)
        ss_cnt <= ss_cnt + 17'h1;
    end
  end

  // ---------------------------------------------------------------
  // flags, read data and registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      top_flags      <= 3'h0;
      ph_flags       <= 6'h0;
      pg_q           <= 1'b0;
      ilim_q         <= 4'h0;
      rd_data_o      <= 8'h00;
      irq_out_n_o    <= 1'b1;
      regulator_on_o <= 1'b0;
      slew_ctrl_o    <= 1'b0;
      spread_o       <= 1'b0;
      ext_clk_sel_o  <= 1'b0;
      pulldown_o     <= 3'h7;
      discharge_o    <= 3'h0;
      host_if_en_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      pg_q   <= power_good_i;
      ilim_q <= phase_ilim_i;
      top_flags <= pwr_bad ? 3'h0 : next_tf;
      ph_flags  <= pwr_bad ? 6'h0 : next_pf;
      irq_out_n_o    <= pwr_bad ? 1'b1 : next_irq_n;
      rd_data_o      <= (rd_i && bus_ok) ? next_rd : 8'h00;
      regulator_on_o <= reg_on;
      slew_ctrl_o    <= reg_on && ss_done;
      spread_o       <= spread_n;
      ext_clk_sel_o  <= ext_sel;
      pulldown_o     <= config_r[3:1];
      discharge_o    <= slv_dis;
      host_if_en_o   <= bus_ok;
    end
  end

endmodule : mprc_top
`default_nettype wire

// [sim/mprc_properties.sv]
// concurrent checks on the regulator control block ports
`timescale 1ns/10ps
`default_nettype none
module mprc_properties (
  input wire logic       mclk_i,         // clock
  input wire logic       sys_rst_i,      // reset
  input wire logic       reset_pin_n_i,  // reset pin
  input wire logic       supply_ok_i,    // supply good
  input wire logic       ce_i,           // clock enable
  input wire logic       host_if_en_o,   // bus open
  input wire logic [3:0] addr_i,         // address
  input wire logic [7:0] wr_data_i,      // write data
  input wire logic       wr_i,           // write
  input wire logic       rd_i,           // read
  input wire logic [7:0] rd_data_o,      // read data
  input wire logic       regulator_on_o, // enable
  input wire logic       slew_ctrl_o,    // ramp
  input wire logic       spread_o,       // spread
  input wire logic       ext_clk_sel_o,  // ext clock
  input wire logic [2:0] pulldown_o,     // pulldowns
  input wire logic [2:0] discharge_o,    // discharge
  input wire logic       irq_out_n_o     // irq
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // no synchronous reset pending and clock enable high, else outputs may drop or lag legally
  wire run = reset_pin_n_i && supply_ok_i && ce_i;
  sequence s_wr(a); run && wr_i && addr_i == a; endsequence
  sequence s_off; host_if_en_o ##0 s_wr(4'h0) ##0 !wr_data_i[0]; endsequence
  property p_pd_rst; $fell(sys_rst_i) |-> pulldown_o == 3'h7; endproperty
  // these outputs move two samples after the taking edge
  property p_pd_hold;
    $changed(pulldown_o) |-> $past(!run || wr_i && addr_i == 4'h8, 2);
  endproperty
  property p_dis_hold;
    $changed(discharge_o) |-> $past(!run || wr_i && addr_i == 4'h2, 2);
  endproperty
  property p_rd_idle; !rd_i |=> rd_data_o == 8'h00; endproperty
  property p_bit_off; s_off |-> ##3 !regulator_on_o; endproperty
  property p_spread; spread_o |-> !ext_clk_sel_o; endproperty
  property p_irq_hold; run && !wr_i && !irq_out_n_o |=> !irq_out_n_o; endproperty
  property p_slew; slew_ctrl_o |-> regulator_on_o; endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("pulldowns off at start");
  a_pd_hold: assert property (p_pd_hold) else $error("pulldowns moved");
  a_dis_hold: assert property (p_dis_hold) else $error("discharge moved");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_bit_off: assert property (p_bit_off) else $error("bit disable late");
  a_spread: assert property (p_spread) else $error("spread on ext clock");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  a_slew: assert property (p_slew) else $error("ramp without enable");
endmodule : mprc_properties
bind mprc_top mprc_properties u_mprc_properties (.*);
`default_nettype wire

// [sim/mprc_host.sv]
// host model: register bus master and enable pins
`timescale 1ns/10ps
`default_nettype none
module mprc_host (
  input  wire logic       clk_i,   // bus clock
  input  wire logic       ready_i, // interface open
  input  wire logic [7:0] rdata_i, // read data
  output logic      [3:0] addr_o,  // address
  output logic      [7:0] wdata_o, // write data
  output logic            wr_o,    // write strobe
  output logic            rd_o,    // read strobe
  output logic      [2:0] pin_o    // enable pins
);
  initial {addr_o, wdata_o, wr_o, rd_o, pin_o} = '0;
  // one access; waits for the interface, which stands in for the boot wait
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] di, output logic [7:0] q);
    while (!ready_i) @(posedge clk_i);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= di;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    {wr_o, rd_o} <= 2'b00;
    @(negedge clk_i);
    q = rdata_i;
  endtask : xfer
  // only one pin is ever given control, so no swap between pins
  task automatic pin(input int i, input logic v);
    @(posedge clk_i);
    pin_o[i] <= v;
  endtask : pin
endmodule : mprc_host
`default_nettype wire

// [sim/mprc_tb_top.sv]
// self-checking bench of the regulator control block
`timescale 1ns/10ps
`default_nettype none
module mprc_tb_top;
  logic mclk_i = 0, sys_rst_i = 1, vout = 1, pg = 0;
  logic ce = 1, sup = 1, rstp = 1, sclk = 0, sck_on = 0;
  logic [3:0] ilim = '0;
  logic [39:0] cur = '0;
  logic [7:0] d;
  wire [3:0] a;
  wire [7:0] wd, rdat;
  wire wr, rd, on, irq_n, hif, slew, spr, ext;
  wire [2:0] pins, pd, dis;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, t;
  int st[4] = '{12, 24, 4, 8};
  initial forever #5 mclk_i = ~mclk_i;
  mprc_host u_mprc_host (.clk_i(mclk_i), .ready_i(hif), .rdata_i(rdat),
    .addr_o(a), .wdata_o(wd), .wr_o(wr), .rd_o(rd), .pin_o(pins));
  mprc_top #(.SS_CYCLES(50), .STEP_A(4), .STEP_B(8),
    .STEP_C(12), .STEP_D(24)) u_mprc_top (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .ce_i(ce), .supply_ok_i(sup),
    .reset_pin_n_i(rstp), .addr_i(a), .wr_data_i(wd), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdat), .enable_pin_i(pins), .sync_clock_in_i(sclk),
    .phase_current_i(cur), .vout_above_i(vout), .power_good_i(pg),
    .phase_ilim_i(ilim), .regulator_on_o(on), .slew_ctrl_o(slew),
    .spread_o(spr), .ext_clk_sel_o(ext), .pulldown_o(pd),
    .discharge_o(dis), .host_if_en_o(hif), .irq_out_n_o(irq_n));
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    samples_checked++;
    if (g !== e) begin n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end
  endtask : chk
  // master pick sums all phases and saturates at the top code
  function automatic logic [9:0] exp_cur(int s, logic [39:0] c);
    logic [11:0] x;
    x = c[9:0] + c[19:10] + c[29:20] + c[39:30];
    if (s != 0) x = {2'b00, c[s*10 +: 10]};
    return (x > 1023) ? 10'h3FF : x[9:0];
  endfunction : exp_cur
  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // sync clock runs at 10 MHz only while a test asks for it
  always @(posedge mclk_i) begin
    sclk <= sck_on && (cyc % 10 >= 5);
    if (++cyc == 40000) begin n_mismatch++; conclude(); end
  end
  initial begin
    void'($urandom(32'hB61C));
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 0;
    u_mprc_host.xfer(0, 4'h8, 0, d); chk("config", 10'h0E, d);
    chk("pulldown", 10'h7, pd);
    u_mprc_host.xfer(1, 4'hA, 0, d);
    for (int s = 0; s < 5; s++) begin
      // even picks stay small; the last pass saturates the master sum
      @(posedge mclk_i) cur <= (s == 4) ? '1 :
        40'({$urandom, $urandom}) & (s[0] ? '1 : {4{10'h0FF}});
      u_mprc_host.xfer(1, 4'h4, 8'(s & 3), d);
      repeat (5002) @(posedge mclk_i);
      #1 chk("irq ready", 0, irq_n);
      u_mprc_host.xfer(0, 4'h5, 0, d); chk("lo", exp_cur(s & 3, cur) & 10'hFF, d);
      u_mprc_host.xfer(0, 4'h6, 0, d); chk("hi", exp_cur(s & 3, cur) >> 8, d & 8'h3);
      u_mprc_host.xfer(0, 4'h9, 0, d); chk("flag", 1, d[0]);
      u_mprc_host.xfer(1, 4'h9, 8'h01, d); chk("irq clear", 1, irq_n);
    end
    $display("measurement test done");
    u_mprc_host.xfer(1, 4'h0, 8'h01, d);
    repeat (2) @(posedge mclk_i);
    #1 chk("bit on", 1, on);
    // a write while the clock enable is low is lost
    @(posedge mclk_i) ce <= 0;
    u_mprc_host.xfer(1, 4'h0, 8'h00, d);
    #1 chk("frozen", 1, on);
    chk("slew", 1, slew);
    @(posedge mclk_i) ce <= 1;
    u_mprc_host.xfer(1, 4'h0, 8'h00, d);
    @(posedge mclk_i) vout <= 0;
    u_mprc_host.xfer(1, 4'h0, 8'h01, d);
    repeat (60) @(posedge mclk_i);
    #1 chk("short off", 0, on);
    @(posedge mclk_i) {pg, ilim} <= 5'h14;
    u_mprc_host.xfer(0, 4'hB, 0, d); chk("short flag", 1, d[1]);
    chk("pg flag", 1, d[0]);
    chk("ilim flag", 1, d[4]);
    u_mprc_host.xfer(1, 4'h0, 8'h00, d);
    @(posedge mclk_i) vout <= 1;
    $display("bit control test done");
    u_mprc_host.xfer(1, 4'h1, 8'h11, d);
    u_mprc_host.xfer(1, 4'h0, 8'h07, d);
    for (int k = 0; k < 4; k++) begin
      u_mprc_host.xfer(1, 4'h8, 8'h0F | 8'(k << 4), d);
      for (int v = 1; v >= 0; v--) begin
        u_mprc_host.pin(1, v[0]);
        for (t = 0; on !== v[0] && t < 40; t++) @(posedge mclk_i);
        chk("pin delay", 1, t >= st[k] && t <= st[k] + 4);
      end
      chk("spread rc", 1, spr);
    end
    u_mprc_host.xfer(1, 4'h7, 8'h29, d); // mode 1, 10 MHz
    @(posedge mclk_i) sck_on <= 1;
    repeat (50) @(posedge mclk_i);
    #1 chk("ext clock", 1, ext);
    chk("spread ext", 0, spr);
    u_mprc_host.xfer(0, 4'h9, 0, d); chk("clock flag", 1, d[1]);
    @(posedge mclk_i) sck_on <= 0;
    repeat (300) @(posedge mclk_i);
    #1 chk("ext lost", 0, ext);
    u_mprc_host.xfer(1, 4'h2, 8'h05, d);
    @(posedge mclk_i) #1 chk("discharge", 5, dis);
    // drop the supply, then the reset pin, in mid-run
    for (int r = 1; r < 3; r++) begin
      u_mprc_host.xfer(1, 4'h8, 8'h00, d);
      @(posedge mclk_i) {sup, rstp} <= 2'(r);
      #1 chk("pulldown off", 0, pd);
      repeat (2) @(posedge mclk_i);
      {sup, rstp} <= 2'h3;
      #1 chk("reset pulldown", 7, pd);
      chk("bus closed", 0, hif);
    end
    u_mprc_host.xfer(1, 4'h3, 8'h5A, d);
    u_mprc_host.xfer(0, 4'h3, 0, d); chk("slave delay", 0, d);
    $display("pin control test done");
    conclude();
  end
endmodule : mprc_tb_top
`default_nettype wire
